// ==== hdl/nv_banks.sv ====
// Nonvolatile bank store with registered read data
module nv_banks (
  input  wire logic        sys_clk_i,
  input  wire logic        we_i,
  input  wire logic [1:0]  waddr_i,
  input  wire logic [12:0] wdata_i,
  input  wire logic [1:0]  raddr_i,
  output logic      [12:0] rdata_o
);
  import sensor_pkg::*;
  // Factory content, in place until the first store lands
  logic [12:0] mem [NV_WORDS] = '{CAL_BANK_RST, {7'h00, CFG_BANK_RST},
                                 {4'h0, RSV_BANK_RST}};

  // No reset: contents survive like the cells they model
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

// ==== hdl/sensor_ctrl.sv ====
// Command interpreter, sensing loop and calibration sequencer
module sensor_ctrl (
  input  wire logic               sys_clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               cal_pin_i,
  output sensor_pkg::pin_drv_t    cal_pin_o,
  input  wire logic               sample_above_i,
  output sensor_pkg::pin_drv_t    out_pin_o,
  output logic                    led_on_o,
  output logic [9:0]              led_drive_count_o,
  output logic [3:0]              threshold_o
);
  import sensor_pkg::*;

  typedef struct packed {
    mode_t       mode;
    logic [2:0]  ld;
    logic [12:0] cal_bank;
    logic [5:0]  cfg_bank;
    logic [8:0]  rsv_bank;
    logic [5:0]  led_cnt;
    logic        hit1;
    logic        det;
    logic        s1;
    logic        s2;
    logic        prev;
    logic [7:0]  edge_cnt;
    logic        half_seen;
    logic [3:0]  nbits;
    logic [11:0] shreg;
    logic [9:0]  drive;
    logic        ref_hit;
    logic [18:0] tmr;
    logic        cal_ok;
    logic        err;
    logic [36:0] frame;
    logic [5:0]  fidx;
    logic        fhalf;
    logic [7:0]  fcnt;
    logic        cal_o;
    logic        cal_oe;
    logic        out_o;
    logic        out_oe;
  } state_t;

  state_t q, d;
  logic        nv_we;
  logic [1:0]  nv_waddr;
  logic [12:0] nv_wdata;
  logic [1:0]  nv_raddr;
  logic [12:0] nv_rdata;
  logic        pulse_end;
  logic        mid_edge;
  logic        bit_val;

  nv_banks u_nv (
    .sys_clk_i (sys_clk_i),
    .we_i      (nv_we),
    .waddr_i   (nv_waddr),
    .wdata_i   (nv_wdata),
    .raddr_i   (nv_raddr),
    .rdata_o   (nv_rdata)
  );

  // Reference met, inverted when inv is set; every caller passes inv = 0
  function automatic logic level_hit(input logic above, input logic inv);
    return above ^ inv;
  endfunction

  // Manchester symbol for one half of a bit
  function automatic logic man_half(input logic b, input logic second);
    return b ^ ~second;
  endfunction

  assign pulse_end = (q.led_cnt == 6'(LED_PER_CYC - 1));
  // A transition counts as mid-bit if none came in the last 3/4 bit
  assign mid_edge  = (q.s2 != q.prev) &&
                     (q.edge_cnt > 8'(HALF_BIT_CYC + HALF_BIT_CYC / 2)
                      || q.half_seen);
  assign bit_val   = q.s2; // [R15]

  always_comb begin
    d         = q;
    nv_we     = 1'b0;
    nv_waddr  = NV_CAL;
    nv_wdata  = 13'h0000;
    nv_raddr  = NV_CAL;

    // Pin synchroniser, second stage only is read
    d.s1   = cal_pin_i;
    d.s2   = q.s1;
    d.prev = q.s2;

    // Time since last pin edge, kept in every mode so that a command
    // right after a busy phase is not timed from a stale edge
    d.edge_cnt = (q.s2 != q.prev) ? 8'h00 :
                 ((q.edge_cnt == 8'hff) ? q.edge_cnt
                                        : q.edge_cnt + 8'h01);

    // Free-running LED pulse timer
    d.led_cnt = pulse_end ? 6'h00 : q.led_cnt + 6'h01; // [R1]

    unique case (q.mode)
      ST_LOAD: begin
        // Fetch each bank in turn after reset
        d.ld = q.ld + 3'h1;
        unique case (q.ld)
          3'h0: nv_raddr = NV_CAL;
          3'h1: nv_raddr = NV_CFG;
          3'h2: nv_raddr = NV_RSV;
          default: nv_raddr = NV_RSV;
        endcase
        if (q.ld == 3'h1) d.cal_bank = nv_rdata; // [R11]
        if (q.ld == 3'h2) d.cfg_bank = nv_rdata[5:0]; // [R11]
        if (q.ld == 3'h3) begin
          d.rsv_bank = nv_rdata[8:0]; // [R14]
          d.mode     = ST_OPER;
        end
      end

      ST_OPER: begin
        // Output follows two agreeing pulse decisions
        if (pulse_end) begin
          d.hit1 = level_hit(sample_above_i, 1'b0);
          if (level_hit(sample_above_i, 1'b0) == q.hit1) begin
            d.det = q.hit1; // [R2] [R3] [R20]
          end
        end
        // Command receiver, one bit per mid-bit edge
        if (q.edge_cnt == 8'hff && q.nbits != 4'h0) begin
          d.nbits = 4'h0; // Idle line drops a partial command
        end
        if (mid_edge) begin
          d.half_seen = 1'b0;
          d.shreg = {q.shreg[10:0], bit_val};
          d.nbits = q.nbits + 4'h1;
          if (q.nbits == 4'h3 &&
              {q.shreg[2:0], bit_val} != SYNC_NIBBLE) begin
            d.nbits = 4'h0; // [R25] [R16]
          end
          if (q.nbits == 4'(CMD_SHORT - 1)) begin
            unique case ({q.shreg[0], bit_val}) // [R17]
              CODE_RSVD:  d.nbits = 4'h0; // [R18]
              CODE_READ: begin // [R19]
                d.nbits = 4'h0;
                d.frame = {1'b0, q.err, q.rsv_bank, q.cal_bank,
                           q.cfg_bank, 7'h00}; // [R23]
                d.fidx  = 6'h00;
                d.fhalf = 1'b0;
                d.fcnt  = 8'h00;
                d.mode  = ST_SEND;
              end
              CODE_CAL: begin // [R19] [R5]
                d.nbits   = 4'h0;
                d.drive   = 10'h000;
                d.ref_hit = 1'b0;
                d.tmr     = 19'h00000;
                d.cal_o   = 1'b1; // [R7]
                d.cal_oe  = 1'b1;
                d.mode    = ST_RAMP;
              end
              CODE_WRITE: ;
            endcase
          end
          if (q.nbits == 4'(CMD_WRITE - 1)) begin
            d.nbits    = 4'h0;
            d.cfg_bank = {q.shreg[4:0], bit_val}; // [R22] [R20]
            d.tmr      = 19'h00000;
            d.mode     = ST_WCHK;
          end
        end else if (q.s2 != q.prev) begin
          d.half_seen = 1'b1; // Bit-boundary edge
        end
        // Configured output driver
        d.out_o  = q.det ^ q.cfg_bank[OP_BIT]; // [R4] [R13]
        d.out_oe = q.cfg_bank[DS_BIT] | ~d.out_o;
      end

      ST_WCHK: begin
        // Store, then read the cell back to check it
        d.tmr    = q.tmr + 19'h00001;
        nv_raddr = NV_CFG;
        if (q.tmr == 19'h00000) begin
          nv_we    = 1'b1;
          nv_waddr = NV_CFG;
          nv_wdata = {7'h00, q.cfg_bank};
        end
        if (q.tmr == 19'h00002) begin
          d.err  = (nv_rdata[5:0] != q.cfg_bank); // [R24]
          d.mode = ST_OPER;
        end
      end

      ST_RAMP: begin
        // One drive step per pulse until two hits in a row
        d.tmr = q.tmr + 19'h00001;
        if (pulse_end) begin
          d.ref_hit = level_hit(sample_above_i, 1'b0);
          if (level_hit(sample_above_i, 1'b0) && q.ref_hit) begin
            d.cal_ok = 1'b1; // [R5]
          end else if (q.drive != DRIVE_MAX) begin
            d.drive = q.drive + 10'h001;
          end
        end
        if (d.cal_ok || q.tmr == 19'(RAMP_CYC - 1) ||
            (pulse_end && q.drive == DRIVE_MAX && !d.cal_ok)) begin
          d.cal_bank = {q.drive, 2'b00, d.cal_ok}; // [R12]
          nv_we      = 1'b1;
          nv_waddr   = NV_CAL;
          nv_wdata   = {q.drive, 2'b00, d.cal_ok};
          d.cal_o    = ~d.cal_ok; // [R8] [R9]
          d.tmr      = 19'h00000;
          d.mode     = ST_STAT; // [R6]
        end
      end

      ST_STAT: begin
        d.tmr = q.tmr + 19'h00001;
        if (q.tmr == 19'(STAT_CYC - 1)) begin // [R6]
          d.cal_oe = 1'b0;
          d.cal_o  = 1'b0;
          d.cal_ok = 1'b0;
          d.mode   = ST_OPER; // [R10]
        end
      end

      ST_SEND: begin
        // Manchester frame on the output pin, MSB of frame first
        d.out_oe = 1'b1;
        d.out_o  = man_half(q.frame[36], q.fhalf); // [R23] [R15]
        d.fcnt   = q.fcnt + 8'h01;
        if (q.fcnt == 8'(HALF_BIT_CYC - 1)) begin
          d.fcnt  = 8'h00;
          d.fhalf = ~q.fhalf;
          if (q.fhalf) begin
            d.frame = {q.frame[35:0], 1'b0};
            d.fidx  = q.fidx + 6'h01;
            if (q.fidx == 6'(FRAME_BITS - 1)) begin
              d.mode = ST_OPER;
            end
          end
        end
      end

      default: d.mode = ST_LOAD;
    endcase
  end

  // Single state register
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q          <= '0;
      q.mode     <= ST_LOAD;
      q.cal_bank <= CAL_BANK_RST;
      q.cfg_bank <= CFG_BANK_RST;
      q.rsv_bank <= RSV_BANK_RST;
      q.out_o    <= 1'b1;
      q.out_oe   <= 1'b1;
      q.edge_cnt <= 8'hff; // Idle line: first edge is a mid-bit
    end else begin
      q <= d;
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      led_on_o          <= 1'b0;
      led_drive_count_o <= 10'h000;
      threshold_o       <= 4'h0;
    end else begin
      led_on_o          <= (q.led_cnt < 6'(LED_ON_CYC)); // [R1]
      led_drive_count_o <= (d.mode == ST_RAMP) ? d.drive
                                               : d.cal_bank[12:3];
      threshold_o       <= d.cfg_bank[3:0]; // [R20]
    end
  end

  assign cal_pin_o.o  = q.cal_o;
  assign cal_pin_o.oe = q.cal_oe;
  assign out_pin_o.o  = q.out_o;
  assign out_pin_o.oe = q.out_oe;

  // LED on-time is exactly 5 of 40 cycles
  property p_led_duty;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(led_on_o) |-> led_on_o [*5] ##1 !led_on_o;
  endproperty
  a_led_duty: assert property (p_led_duty) // [R1]
    else $error("LED on-time wrong");

  property p_ramp_high;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      q.mode == ST_RAMP |-> q.cal_o && q.cal_oe;
  endproperty
  a_ramp_high: assert property (p_ramp_high) // [R7]
    else $error("Status pin not high in ramp");

  property p_stat_ok;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      q.mode == ST_STAT && q.cal_ok |-> !q.cal_o && q.cal_oe;
  endproperty
  a_stat_ok: assert property (p_stat_ok) // [R8]
    else $error("Status pin not low after success");

  property p_stat_fail;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      q.mode == ST_STAT && !q.cal_ok |-> q.cal_o;
  endproperty
  a_stat_fail: assert property (p_stat_fail) // [R9]
    else $error("Status pin low after failure");

  property p_ramp_len;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      q.mode == ST_RAMP |-> q.tmr < 19'(RAMP_CYC);
  endproperty
  a_ramp_len: assert property (p_ramp_len) // [R6]
    else $error("Ramp too long");

  property p_det_stable;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      $changed(q.det) |-> $past(pulse_end) && $past(q.mode) == ST_OPER;
  endproperty
  a_det_stable: assert property (p_det_stable) // [R2]
    else $error("Output changed off a pulse");

  property p_thr_now;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      threshold_o == q.cfg_bank[3:0];
  endproperty
  a_thr_now: assert property (p_thr_now) // [R20]
    else $error("Threshold not applied");

  property p_sync_drop;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      q.mode == ST_OPER && mid_edge && q.nbits == 4'h3 &&
      {q.shreg[2:0], bit_val} != SYNC_NIBBLE |=> q.nbits == 4'h0;
  endproperty
  a_sync_drop: assert property (p_sync_drop) // [R25]
    else $error("Bad sync kept");

  property p_rsvd_code;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      q.mode == ST_OPER && mid_edge && q.nbits == 4'h5 &&
      {q.shreg[0], bit_val} == CODE_RSVD |=> q.mode == ST_OPER;
  endproperty
  a_rsvd_code: assert property (p_rsvd_code) // [R18]
    else $error("Reserved code acted on");
endmodule

// ==== hdl/sensor_pkg.sv ====
// Constants and types shared by the optical sensor command controller
// Function
// [R1] LED on 250 ns every 2 us period
// [R2] Output changes after two agreeing pulses
// [R3] Sample compared against 4-bit threshold code
// [R4] Default output inverted push-pull, low on target
// [R5] Calibrate ramps drive up, stores reached count
// [R6] Ramp at most 17 ms, status 13 ms
// [R7] Status pin high during whole ramp
// [R8] Successful ramp drives status pin low
// [R9] Failed ramp keeps status pin high
// [R10] Stay sensing until valid command arrives
// [R11] Power-up restores drive, threshold, output config
// [R12] Calibration bank: count 12:3, ok flag bit 0
// [R13] Config bank: invert 5, drive 4, threshold 3:0
// [R14] Third bank holds nine reserved bits
// [R15] Manchester: zero falls, one rises mid-bit
// [R16] Host starts commands with sync 1100
// [R17] Code after sync: read, write, calibrate
// [R18] Code 00 is reserved, no action
// [R19] Read and calibrate are six bits
// [R20] New threshold applies to comparator at once
// [R21] Host writes config, calibrates, writes threshold
// [R22] Write is twelve bits, data MSB first
// [R23] Read answers 37-bit Manchester frame, 100 kb/s
// [R24] Bank write read back sets error flag
// [R25] Bad sync sequence is discarded
package sensor_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned LED_ON_NS     = 250;
  localparam int unsigned LED_PER_NS    = 2000;
  localparam int unsigned LED_ON_CYC    = (LED_ON_NS * 20) / 1000;
  localparam int unsigned LED_PER_CYC   = (LED_PER_NS * 20) / 1000;
  localparam int unsigned RAMP_MAX_MS   = 17;
  localparam int unsigned STAT_MS       = 13;
  localparam int unsigned RAMP_CYC      = RAMP_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned STAT_CYC      = STAT_MS * (CLK_HZ / 1000);
  localparam int unsigned BIT_RATE      = 100_000;
  localparam int unsigned HALF_BIT_CYC  = CLK_HZ / (2 * BIT_RATE);
  localparam int unsigned FRAME_BITS    = 37;
  localparam int unsigned CMD_SHORT     = 6;
  localparam int unsigned CMD_WRITE     = 12;
  localparam logic [3:0]  SYNC_NIBBLE   = 4'h0c;
  localparam logic [1:0]  CODE_RSVD     = 2'h0;
  localparam logic [1:0]  CODE_READ     = 2'h1;
  localparam logic [1:0]  CODE_WRITE    = 2'h2;
  localparam logic [1:0]  CODE_CAL      = 2'h3;
  localparam int unsigned OP_BIT        = 5;
  localparam int unsigned DS_BIT        = 4;
  localparam logic [9:0]  DRIVE_MAX     = 10'h3ff;
  localparam logic [12:0] CAL_BANK_RST  = 13'h0000;
  localparam logic [5:0]  CFG_BANK_RST  = 6'h30;
  localparam logic [8:0]  RSV_BANK_RST  = 9'h000;
  localparam int unsigned NV_WORDS      = 3;
  localparam logic [1:0]  NV_CAL        = 2'h0;
  localparam logic [1:0]  NV_CFG        = 2'h1;
  localparam logic [1:0]  NV_RSV        = 2'h2;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b000, ST_OPER = 3'b001, ST_RAMP = 3'b011,
    ST_STAT = 3'b010, ST_SEND = 3'b110, ST_WCHK = 3'b111
  } mode_t;

  typedef struct packed {
    logic o;
    logic oe;
  } pin_drv_t;
endpackage

// ==== tb/host_model.sv ====
// Host model that sends Manchester commands on the calibrate pin
module host_model (
  input  wire logic sys_clk_i,
  input  wire logic dev_oe_i,
  output logic      drv_o,
  output logic      oe_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Line released at start, the pull-down holds it low
  initial begin
    drv_o = 1'b0;
    oe_o  = 1'b0;
  end

  // One half bit of 100 cycles, level changed just after an edge
  task automatic half(input logic lvl);
    @(posedge sys_clk_i);
    #1 drv_o = lvl;
    repeat (99) @(posedge sys_clk_i);
  endtask

  // Mid-bit fall codes a zero, mid-bit rise a one
  task automatic put_bit(input logic b);
    half(~b);
    half(b);
  endtask

  // Sync and code, then six data bits MSB first when writing
  task automatic send(input logic [5:0] head, input logic [5:0] data,
                      input logic with_data);
    int i;
    // Do not start talking while the device drives the pin
    while (dev_oe_i) begin
      @(posedge sys_clk_i);
    end
    @(posedge sys_clk_i);
    #1 oe_o = 1'b1;
    for (i = 5; i >= 0; i--) begin
      put_bit(head[i]);
    end
    if (with_data) begin
      for (i = 5; i >= 0; i--) begin
        put_bit(data[i]);
      end
    end
    @(posedge sys_clk_i);
    #1 oe_o = 1'b0;
    drv_o = 1'b0;
  endtask
endmodule

// ==== tb/tb_optical_sensor_cmd_controller.sv ====
// Self-checking bench for the optical sensor command controller
`define CHK(got, exp, msg) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("CHECK FAILED t=%0t %s", $time, msg); \
    end \
  end

module tb_optical_sensor_cmd_controller;
  timeunit 1ns;
  timeprecision 1ps;
  import sensor_pkg::*;

  logic        sys_clk_i;
  logic        sys_rst_i;
  logic        cal_lvl;
  logic        out_lvl;
  logic        host_o;
  logic        host_oe;
  logic        cal_mode;
  logic        plain_above;
  logic        sample_above_i;
  pin_drv_t    cal_pin_o;
  pin_drv_t    out_pin_o;
  logic        led_on_o;
  logic [9:0]  led_drive_count_o;
  logic [3:0]  threshold_o;
  logic [36:0] frame;
  int          k;
  int          j;
  int          n_errors = 0;
  int          total_checks = 0;

  sensor_ctrl dut_u (
    .sys_clk_i         (sys_clk_i),
    .sys_rst_i         (sys_rst_i),
    .cal_pin_i         (cal_lvl),
    .cal_pin_o         (cal_pin_o),
    .sample_above_i    (sample_above_i),
    .out_pin_o         (out_pin_o),
    .led_on_o          (led_on_o),
    .led_drive_count_o (led_drive_count_o),
    .threshold_o       (threshold_o)
  );

  host_model host_u (
    .sys_clk_i (sys_clk_i),
    .dev_oe_i  (cal_pin_o.oe),
    .drv_o     (host_o),
    .oe_o      (host_oe)
  );

  // Pin levels: pull-down on calibrate pin, pull-up on output pin
  assign cal_lvl = cal_pin_o.oe ? cal_pin_o.o : (host_oe ? host_o : 1'b0);
  assign out_lvl = out_pin_o.oe ? out_pin_o.o : 1'b1;
  // Target plant: in calibration it answers from drive count 20 up
  assign sample_above_i = cal_mode ? (led_drive_count_o >= 10'h014)
                                   : plain_above;

  // 20 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // Inputs move 1 ns after the edge, clear of sampling
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic note(input string msg);
    $display("Test done: %s", msg);
  endtask

  task automatic stop_test();
    $display("Counts: %0d checks, %0d errors", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Loose band: exact stop count depends on hit pipelining
  function automatic logic near(input logic [9:0] c);
    return c inside {[10'h014:10'h016]};
  endfunction

  task automatic write_cfg(input logic [5:0] v);
    host_u.send(6'b110010, v, 1'b1);
    step(300);
  endtask

  task automatic refused(input logic [5:0] head);
    host_u.send(head, 6'h00, 1'b0);
    `CHK(cal_pin_o, 2'b00, "command not ignored")
    step(400);
    `CHK(threshold_o, 4'h5, "config disturbed")
  endtask

  // Anchor on the mid-bit fall of the start bit, then sample halves
  task automatic read_frame();
    logic first;
    int   i;
    // Detector must settle first, or its own switch looks like a frame
    for (i = 0; i < 3000 && out_lvl !== 1'b0; i++) step(1);
    fork
      host_u.send(6'b110001, 6'h00, 1'b0);
      begin
        for (i = 0; i < 3000 && out_lvl !== 1'b1; i++) step(1);
        for (i = 0; i < 3000 && out_lvl !== 1'b0; i++) step(1);
        step(50);
        frame[36] = out_lvl;
        for (i = 35; i >= 0; i--) begin
          step(100);
          first = out_lvl;
          step(100);
          frame[i] = out_lvl;
          `CHK(first, ~frame[i], "frame halves not opposite")
        end
        // Pin is ignored until the device is back in operate
        step(200);
      end
    join
  endtask

  // Main sequence
  initial begin
    sys_rst_i   = 1'b1;
    cal_mode    = 1'b0;
    plain_above = 1'b0;
    step(20);
    `CHK(out_pin_o, 2'b11, "out pin in reset")
    `CHK(cal_pin_o, 2'b00, "cal pin in reset")
    sys_rst_i = 1'b0;
    step(10);
    `CHK(threshold_o, CFG_BANK_RST[3:0], "threshold from store")
    write_cfg(6'h35);
    `CHK(threshold_o, 4'h5, "threshold after write")
    step(200);
    `CHK(out_pin_o, 2'b11, "no target must drive high")
    plain_above = 1'b1;
    step(30);
    `CHK(out_pin_o, 2'b11, "switched after one pulse")
    step(70);
    `CHK(out_pin_o, 2'b01, "target must drive low")
    note("sensing");
    refused(6'b110000);
    refused(6'b101011);
    note("refused");
    cal_mode = 1'b1;
    host_u.send(6'b110011, 6'h00, 1'b0);
    `CHK(cal_pin_o, 2'b11, "cal pin not high in ramp")
    for (k = 0; k < 2000 && cal_lvl !== 1'b0; k++) step(1);
    `CHK(cal_pin_o, 2'b01, "no status low after ramp")
    `CHK(near(led_drive_count_o), 1'b1, "reached drive")
    step(1000);
    `CHK(cal_pin_o, 2'b01, "status low not held")
    note("calibrate");
    // Second reset in mid status; banks must come back
    sys_rst_i = 1'b1;
    step(2);
    sys_rst_i = 1'b0;
    step(10);
    `CHK(threshold_o, 4'h5, "threshold not restored")
    `CHK(near(led_drive_count_o), 1'b1, "drive not restored")
    read_frame();
    `CHK(frame[36], 1'b0, "start bit")
    `CHK(frame[35], 1'b0, "error flag")
    `CHK(frame[34:26], RSV_BANK_RST, "frame reserved bank")
    `CHK(near(frame[25:16]), 1'b1, "frame drive count")
    `CHK(frame[13], 1'b1, "frame ok flag")
    `CHK(frame[12:7], 6'h35, "frame config")
    `CHK(frame[6:0], 7'h00, "frame tail")
    note("read");
    write_cfg(6'h33);
    `CHK(threshold_o, 4'h3, "new threshold")
    j = 0;
    for (k = 0; k < 40; k++) begin
      step(1);
      if (led_on_o === 1'b1) j++;
    end
    `CHK(j, 5, "LED on cycles per period")
    note("final write and LED");
    stop_test();
  end

  // Watchdog: the sequence needs about 21000 cycles
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    n_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    stop_test();
  end
endmodule
